// [inc/i2cack_map.vh]
/*
 Constants for the two-wire target acknowledge-timing block.
 Assumes inclusion by bare name from design files.
*/
`ifndef I2CACK_MAP_VH
`define I2CACK_MAP_VH
`define I2CACK_BITS_PER_BYTE 4'd8
`define I2CACK_TENBIT_HDR 5'h1e
`define I2CACK_ST_IDLE 3'd0
`define I2CACK_ST_RECV 3'd1
`define I2CACK_ST_ACKT 3'd2
`define I2CACK_ST_HOLD 3'd3
`define I2CACK_ST_ACKD 3'd4
`define I2CACK_ST_SKIP 3'd5
`endif

// [verilog/i2cack_fifo.v]
/*
 Synchronous FIFO with valid/ready on both sides.
 Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ns
`default_nettype none
module i2cack_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire mclk_i,
    input wire rst_n_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_reg;
    reg [AW:0] rd_reg;
    wire full = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
    wire empty = (wr_reg == rd_reg);
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = mem[rd_reg[AW-1:0]];
    always @(posedge mclk_i) begin
        if (in_valid_i && !full) begin
            mem[wr_reg[AW-1:0]] <= in_data_i;
        end
    end
    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            wr_reg <= {(AW+1){1'b0}};
            rd_reg <= {(AW+1){1'b0}};
        end else begin
            if (in_valid_i && !full) begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (out_ready_i && !empty) begin
                rd_reg <= rd_reg + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// [verilog/i2cack_target.v]
/*
 Two-wire bus target: byte reception, acknowledge-time flag, address hold
 stretching, software NACK, ten-bit addressing and a receive FIFO.
 Assumes bus pins are external and open-drain; outputs enable pulls low.
*/
`timescale 1ns/1ns
`default_nettype none
`include "i2cack_map.vh"
// Operation
// - Flag rises at eighth clock fall, drops at ninth clock rise.
// - With hold enabled, clock held low after eighth fall; flag stays set.
// - Hold disabled: no stretching, flag only during the short acknowledge gap.
// - Ten-bit: upper byte with bits nine and eight, then lower, then data.
// - Ten-bit mode flags acknowledge of lower address byte and each data byte.
// - With hold enabled software may NACK any byte until Stop.
// - Receive-buffer-full flag shows a received byte, including upper address.
module i2cack_target #(
    parameter [9:0] OWN_ADDR = 10'h05a,
    parameter FIFO_DEPTH = 16
) (
    input wire mclk_i,
    input wire rst_n_i,
    input wire scl_i,
    output wire scl_o,
    output wire scl_oe_o,
    input wire sda_i,
    output wire sda_o,
    output wire sda_oe_o,
    input wire address_hold_enable_i,
    input wire ten_bit_mode_i,
    input wire nack_select_i,
    input wire release_i,
    output reg ack_time_flag_o,
    output wire receive_buffer_full_o,
    output wire [7:0] rx_data_o,
    input wire rx_read_i,
    output wire overflow_o
);
    reg [1:0] scl_sync_reg;
    reg [1:0] sda_sync_reg;
    reg scl_d_reg;
    reg sda_d_reg;
    reg [2:0] state_reg;
    reg [3:0] bit_cnt_reg;
    reg [7:0] shift_reg;
    reg [1:0] phase_reg;
    reg nack_reg;
    reg stretch_reg;
    reg sda_low_reg;
    reg push_reg;
    reg [7:0] push_data_reg;
    reg ovf_reg;
    wire scl_s = scl_sync_reg[1];
    wire sda_s = sda_sync_reg[1];
    wire scl_rise = scl_s && !scl_d_reg;
    wire scl_fall = !scl_s && scl_d_reg;
    wire start_c = scl_s && scl_d_reg && sda_d_reg && !sda_s;
    wire stop_c = scl_s && scl_d_reg && !sda_d_reg && sda_s;
    wire fifo_ready;
    // phase: 0 first address byte, 1 lower ten-bit address, 2 data
    wire [7:0] byte_now = {shift_reg[6:0], sda_s};
    // Eighth falling edge closes the byte being shifted in
    wire byte_done = scl_fall && (bit_cnt_reg == `I2CACK_BITS_PER_BYTE);
    wire byte_ok = addr_ok_q(phase_reg, shift_reg);
    // flag suppressed on upper ten-bit byte
    wire flag_this = !(ten_bit_mode_i && phase_reg == 2'd0);
    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            scl_sync_reg <= 2'b11;
            sda_sync_reg <= 2'b11;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], scl_i};
            sda_sync_reg <= {sda_sync_reg[0], sda_i};
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end
    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state_reg <= `I2CACK_ST_IDLE;
            bit_cnt_reg <= 4'd0;
            shift_reg <= 8'h00;
            phase_reg <= 2'd0;
            nack_reg <= 1'b0;
            stretch_reg <= 1'b0;
            sda_low_reg <= 1'b0;
            ack_time_flag_o <= 1'b0;
            push_reg <= 1'b0;
            push_data_reg <= 8'h00;
            ovf_reg <= 1'b0;
        end else begin
            push_reg <= 1'b0;
            if (start_c) begin
                state_reg <= `I2CACK_ST_RECV;
                bit_cnt_reg <= 4'd0;
                phase_reg <= 2'd0;
                sda_low_reg <= 1'b0;
                stretch_reg <= 1'b0;
                ack_time_flag_o <= 1'b0;
            end else if (stop_c) begin
                state_reg <= `I2CACK_ST_IDLE;
                sda_low_reg <= 1'b0;
                stretch_reg <= 1'b0;
                ack_time_flag_o <= 1'b0;
            end else begin
                case (state_reg)
                    `I2CACK_ST_IDLE: begin
                        sda_low_reg <= 1'b0;
                    end
                    `I2CACK_ST_RECV: begin
                        if (scl_rise) begin
                            shift_reg <= byte_now;
                            bit_cnt_reg <= bit_cnt_reg + 4'd1;
                        end else if (byte_done) begin
                            bit_cnt_reg <= 4'd0;
                            if (!byte_ok) begin
                                state_reg <= `I2CACK_ST_SKIP;
                            end else begin
                                // every accepted byte goes to the buffer; when the buffer is full the byte is dropped and overflow is set
                                if (fifo_ready) begin
                                    push_reg <= 1'b1;
                                    push_data_reg <= shift_reg;
                                end else begin
                                    ovf_reg <= 1'b1;
                                end
                                ack_time_flag_o <= flag_this;
                                if (address_hold_enable_i) begin
                                    stretch_reg <= 1'b1;
                                    state_reg <= `I2CACK_ST_HOLD;
                                end else begin
                                    sda_low_reg <= fifo_ready;
                                    nack_reg <= !fifo_ready;
                                    state_reg <= `I2CACK_ST_ACKT;
                                end
                            end
                        end
                    end
                    `I2CACK_ST_HOLD: begin
                        if (release_i) begin
                            stretch_reg <= 1'b0;
                            sda_low_reg <= !nack_select_i;
                            nack_reg <= nack_select_i;
                            state_reg <= `I2CACK_ST_ACKT;
                        end
                    end
                    `I2CACK_ST_ACKT: begin
                        if (scl_rise) begin
                            ack_time_flag_o <= 1'b0;
                            state_reg <= `I2CACK_ST_ACKD;
                        end
                    end
                    `I2CACK_ST_ACKD: begin
                        if (scl_fall) begin
                            sda_low_reg <= 1'b0;
                            if (nack_reg) begin
                                state_reg <= `I2CACK_ST_SKIP;
                            end else begin
                                if (phase_reg == 2'd0) begin
                                    phase_reg <= ten_bit_mode_i ? 2'd1 : 2'd2;
                                end else begin
                                    phase_reg <= 2'd2;
                                end
                                state_reg <= `I2CACK_ST_RECV;
                            end
                        end
                    end
                    `I2CACK_ST_SKIP: begin
                        sda_low_reg <= 1'b0;
                    end
                    default: begin
                        state_reg <= `I2CACK_ST_IDLE;
                    end
                endcase
            end
        end
    end
    function addr_ok_q;
        input [1:0] ph;
        input [7:0] b;
        begin
            if (ph == 2'd0) begin
                addr_ok_q = ten_bit_mode_i ?
                    ((b[7:3] == `I2CACK_TENBIT_HDR) && (b[2:1] == OWN_ADDR[9:8]) && !b[0]) :
                    ((b[7:1] == OWN_ADDR[6:0]) && !b[0]);
            end else if (ph == 2'd1) begin
                addr_ok_q = (b == OWN_ADDR[7:0]);
            end else begin
                addr_ok_q = 1'b1;
            end
        end
    endfunction
    assign scl_o = 1'b0;
    assign scl_oe_o = stretch_reg;
    assign sda_o = 1'b0;
    assign sda_oe_o = sda_low_reg;
    assign overflow_o = ovf_reg;
    i2cack_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH),
        .AW(4)
    ) u_fifo (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(push_reg),
        .in_ready_o(fifo_ready),
        .in_data_i(push_data_reg),
        .out_valid_o(receive_buffer_full_o),
        .out_ready_i(rx_read_i),
        .out_data_o(rx_data_o)
    );
endmodule
`default_nettype wire

// [tb/i2cack_asserts.sv]
/*
 Concurrent checks on the acknowledge-timing target's ports.
 Assumes one clock domain and the synchronous active-low reset.
*/
`timescale 1ns/1ns
`default_nettype none
module i2cack_asserts (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic scl_i,
    input wire logic scl_oe_o,
    input wire logic sda_oe_o,
    input wire logic address_hold_enable_i,
    input wire logic release_i,
    input wire logic nack_select_i,
    input wire logic ack_time_flag_o,
    input wire logic receive_buffer_full_o,
    input wire logic overflow_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_rel_ack;
        scl_oe_o && release_i && !nack_select_i;
    endsequence
    sequence s_rel_nack;
        scl_oe_o && release_i && nack_select_i;
    endsequence
    AST_NO_STRETCH: assert property (!address_hold_enable_i && !$past(address_hold_enable_i) |-> !scl_oe_o) else $error("stretch without hold");
    AST_HOLD: assert property (scl_oe_o && !release_i |=> scl_oe_o) else $error("stretch ended early");
    AST_FREE: assert property (scl_oe_o && release_i |=> ##[0:1] !scl_oe_o) else $error("clock not freed");
    AST_ACK: assert property (s_rel_ack |=> ##[0:1] sda_oe_o) else $error("no ack after release");
    AST_NACK: assert property (s_rel_nack |=> !sda_oe_o [*3]) else $error("ack despite nack");
    AST_FLAG_DROP: assert property (ack_time_flag_o && $rose(scl_i) |-> ##[1:6] !ack_time_flag_o) else $error("flag stuck");
    AST_FLAG_RISE: assert property ($rose(ack_time_flag_o) |-> !scl_i) else $error("flag rose with clock high");
    AST_RBF_PUSH: assert property ($rose(scl_oe_o) |=> receive_buffer_full_o) else $error("stretch without byte");
    AST_OVF_STICKY: assert property (overflow_o |=> overflow_o) else $error("overflow flag lost");
    AST_RST: assert property (@(posedge mclk_i) disable iff (1'b0) !rst_n_i |=> !scl_oe_o && !sda_oe_o) else $error("bus driven in reset");
endmodule
bind i2cack_target i2cack_asserts i_i2cack_asserts (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .scl_i(scl_i), .scl_oe_o(scl_oe_o), .sda_oe_o(sda_oe_o),
    .address_hold_enable_i(address_hold_enable_i), .release_i(release_i),
    .nack_select_i(nack_select_i), .ack_time_flag_o(ack_time_flag_o),
    .receive_buffer_full_o(receive_buffer_full_o), .overflow_o(overflow_o));
`default_nettype wire

// [tb/i2cack_ctrl_model.sv]
/*
 Bus controller model: Start, Stop and byte writes, honouring stretching.
 Assumes pull-ups on both wires; an output high pulls its wire low.
*/
`timescale 1ns/1ns
`default_nettype none
module i2cack_ctrl_model (
    input wire logic mclk_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_pull_o = 1'b0,
    output logic sda_pull_o = 1'b0
);
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    task automatic start_cond();
        sda_pull_o <= 1'b1;
        tick(4);
        scl_pull_o <= 1'b1;
        tick(2);
    endtask
    task automatic stop_cond();
        sda_pull_o <= 1'b1;
        tick(2);
        scl_pull_o <= 1'b0;
        tick(4);
        sda_pull_o <= 1'b0;
        tick(4);
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack);
        int n;
        for (int i = 7; i >= 0; i--) begin
            sda_pull_o <= ~b[i];
            tick(2);
            scl_pull_o <= 1'b0;
            tick(4);
            scl_pull_o <= 1'b1;
            tick(2);
        end
        sda_pull_o <= 1'b0;
        tick(4);
        scl_pull_o <= 1'b0;
        n = 0;
        tick(1);
        // Waits out a stretched clock before the ninth high phase
        while (scl_i !== 1'b1 && n < 3000) begin
            tick(1);
            n++;
        end
        tick(3);
        ack = !sda_i;
        scl_pull_o <= 1'b1;
        tick(2);
    endtask
endmodule
`default_nettype wire

// [tb/i2cack_target_tb.sv]
/*
 Self-checking bench for the acknowledge-timing target in ten-bit and seven-bit modes.
 Assumes the controller model and the bound checker are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module i2cack_target_tb;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic hold_en = 1'b0;
    logic nack_sel = 1'b0;
    logic rel = 1'b0;
    logic rd = 1'b0;
    logic ten_bit = 1'b1;
    logic ack, seen;
    logic scl_pull, sda_pull;
    wire scl_oe, sda_oe, flag, receive_buffer_full, ovf;
    wire [7:0] rxd;
    wire scl = !(scl_pull | scl_oe);
    wire sda = !(sda_pull | sda_oe);
    int errors = 0;
    int tests_run = 0;
    int cyc = 0;
    int n;
    i2cack_target i_i2cack_target (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .scl_i(scl), .scl_o(),
        .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe),
        .address_hold_enable_i(hold_en), .ten_bit_mode_i(ten_bit), .nack_select_i(nack_sel),
        .release_i(rel), .ack_time_flag_o(flag), .receive_buffer_full_o(receive_buffer_full),
        .rx_data_o(rxd), .rx_read_i(rd), .overflow_o(ovf));
    i2cack_ctrl_model i_i2cack_ctrl_model (.mclk_i(mclk_i), .scl_i(scl), .sda_i(sda),
        .scl_pull_o(scl_pull), .sda_pull_o(sda_pull));
    initial forever #5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (flag === 1'b1) seen <= 1'b1;
        if (cyc == 20000) begin
            errors++;
            report_and_stop();
        end
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        tests_run++;
        if (s !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic s);
        chk(nm, {7'h00, e}, {7'h00, s});
    endtask
    task automatic sw(input logic nk, input logic fl);
        n = 0;
        while (scl_oe !== 1'b1 && n < 200) begin
            @(posedge mclk_i);
            n++;
        end
        repeat (20) @(posedge mclk_i);
        chk1("stretch", 1'b1, scl_oe);
        chk1("flag_held", fl, flag);
        nack_sel <= nk;
        rel <= 1'b1;
        @(posedge mclk_i);
        rel <= 1'b0;
        n = 0;
        while (scl !== 1'b1 && n < 50) begin
            @(posedge mclk_i);
            n++;
        end
        repeat (8) @(posedge mclk_i);
        chk1("flag_clear", 1'b0, flag);
    endtask
    task automatic xfer(input logic [7:0] b, input logic nk, input logic fl, input logic ea);
        seen <= 1'b0;
        if (hold_en) fork
            i_i2cack_ctrl_model.send_byte(b, ack);
            sw(nk, fl);
        join
        else i_i2cack_ctrl_model.send_byte(b, ack);
        chk1("ack", ea, ack);
        chk1("flag_seen", fl, seen);
    endtask
    task automatic t_nohold();
        hold_en <= 1'b0;
        i_i2cack_ctrl_model.start_cond();
        xfer(8'hf0, 1'b0, 1'b0, 1'b1);
        chk1("rbf", 1'b1, receive_buffer_full);
        chk("head", 8'hf0, rxd);
        xfer(8'h5a, 1'b0, 1'b1, 1'b1);
        xfer(8'ha5, 1'b0, 1'b1, 1'b1);
        repeat (16) i_i2cack_ctrl_model.send_byte(8'h3c, ack);
        chk1("overflow", 1'b1, ovf);
        i_i2cack_ctrl_model.stop_cond();
        n = 0;
        while (receive_buffer_full === 1'b1 && n < 20) begin
            rd <= 1'b1;
            @(posedge mclk_i);
            rd <= 1'b0;
            @(posedge mclk_i);
            n++;
        end
        chk("drained", 8'd16, n[7:0]);
    endtask
    task automatic t_seven();
        ten_bit <= 1'b0;
        hold_en <= 1'b0;
        i_i2cack_ctrl_model.start_cond();
        xfer(8'hb4, 1'b0, 1'b1, 1'b1);
        i_i2cack_ctrl_model.stop_cond();
        i_i2cack_ctrl_model.start_cond();
        xfer(8'h12, 1'b0, 1'b0, 1'b0);
        i_i2cack_ctrl_model.stop_cond();
    endtask
    task automatic t_hold();
        hold_en <= 1'b1;
        i_i2cack_ctrl_model.start_cond();
        xfer(8'hf0, 1'b0, 1'b0, 1'b1);
        xfer(8'h5a, 1'b0, 1'b1, 1'b1);
        xfer(8'ha5, 1'b1, 1'b1, 1'b0);
        i_i2cack_ctrl_model.stop_cond();
        i_i2cack_ctrl_model.start_cond();
        xfer(8'hf0, 1'b1, 1'b0, 1'b0);
        i_i2cack_ctrl_model.stop_cond();
    endtask
    task automatic report_and_stop();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        t_nohold();
        t_hold();
        t_seven();
        report_and_stop();
    end
endmodule
`default_nettype wire
